/* hdl/eeprom_pkg.sv */
package eeprom_pkg;
  localparam int ADDR_W = 13;
  localparam int OFF_W = 5;
  localparam int PAGE_W = 8;
  localparam int MEM_BYTES = 8192;
  localparam int PAGES = 256;
  localparam int PAGE_BYTES = 32;
  localparam int FIFO_DEPTH = 16;
  localparam logic [3:0] CMD_PREFIX = 4'ha;
  localparam logic [1:0] LOCK_READ_CODE = 2'h0;
  localparam logic [1:0] LOCK_SET_CODE = 2'h1;
  localparam logic [1:0] LOCK_CLEAR_CODE = 2'h3;
  localparam logic [7:0] ERASED_BYTE = 8'hff;
  localparam logic [3:0] BIT_ACK = 4'h8;
  localparam logic [3:0] BIT_END = 4'h9;
  localparam logic [5:0] VERIFY_LAST = 6'h20;
  localparam logic [5:0] PINS_RESET = 6'h30;
  // programming times and their cycle counts at mclk
  localparam int CLK_PERIOD_NS = 8;
  localparam int PROG_TIME_MS = 8;
  localparam int LOCK_TIME_MS = 4;
  localparam int PROG_CYCLES = PROG_TIME_MS * 1000000 / CLK_PERIOD_NS;
  localparam int LOCK_CYCLES = LOCK_TIME_MS * 1000000 / CLK_PERIOD_NS;
  localparam int TIMER_W = 24;

  typedef enum logic [3:0] {
    S_IDLE, S_CMD, S_ADDR_HI, S_ADDR_LO, S_WDATA, S_RDATA,
    S_LOCK_CTL, S_LOCK_VERIFY, S_LOCK_READ, S_IGNORE
  } bus_state_type;

  typedef struct packed {
    logic [4:0] offset;
    logic [7:0] data;
  } page_write_type;

  typedef struct packed {
    logic scl;
    logic sda;
    logic wp;
    logic [2:0] sel;
  } pins_type;
endpackage : eeprom_pkg

/* hdl/page_fifo.sv */
`timescale 1ns/1ps
module page_fifo #(
  parameter int WIDTH = 13,
  parameter int DEPTH = 16
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] store [DEPTH];
  logic [AW:0] wr_ptr;
  logic [AW:0] rd_ptr;
  logic full;

  // extra pointer bit tells full from empty
  assign full = (wr_ptr[AW] != rd_ptr[AW]) &&
                (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
  assign in_ready = !full;
  assign out_valid = wr_ptr != rd_ptr;
  assign out_data = store[rd_ptr[AW-1:0]];

  // write side
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      wr_ptr <= '0;
    end else if (in_valid && !full) begin
      store[wr_ptr[AW-1:0]] <= in_data;
      wr_ptr <= wr_ptr + 1'b1;
    end
  end

  // read side
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      rd_ptr <= '0;
    end else if (out_valid && out_ready) begin
      rd_ptr <= rd_ptr + 1'b1;
    end
  end
endmodule : page_fifo

/* hdl/serial_eeprom_slave.sv */
`timescale 1ns/1ps
module serial_eeprom_slave #(
  parameter int PROG_CYCLES = eeprom_pkg::PROG_CYCLES,
  parameter int LOCK_CYCLES = eeprom_pkg::LOCK_CYCLES,
  parameter int FIFO_DEPTH = eeprom_pkg::FIFO_DEPTH
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic scl,
  input wire logic sda_in,
  input wire logic write_protect,
  input wire logic dev_sel_bit0,
  input wire logic dev_sel_bit1,
  input wire logic dev_sel_bit2,
  output logic sda_out,
  output logic sda_oe,
  output logic prog_busy
);
  localparam int PW = $bits(eeprom_pkg::page_write_type);
  localparam logic [eeprom_pkg::TIMER_W-1:0] PROG_LAST =
    eeprom_pkg::TIMER_W'(PROG_CYCLES - 1);
  localparam logic [eeprom_pkg::TIMER_W-1:0] LOCK_LAST =
    eeprom_pkg::TIMER_W'(LOCK_CYCLES - 1);

  eeprom_pkg::pins_type meta, pins, pins_d;
  eeprom_pkg::bus_state_type state;
  eeprom_pkg::page_write_type push_word, pop_word;
  logic [7:0] mem [eeprom_pkg::MEM_BYTES];
  logic [eeprom_pkg::PAGES-1:0] lock;
  logic [7:0] pbuf [eeprom_pkg::PAGE_BYTES];
  logic [eeprom_pkg::PAGE_BYTES-1:0] pmask;
  logic [eeprom_pkg::ADDR_W-1:0] addr;
  logic [3:0] bit_cnt;
  logic [7:0] shift_in;
  logic [7:0] tx_byte;
  logic [7:0] rd_byte;
  logic [1:0] lock_ctl;
  logic [5:0] verify_cnt;
  logic [eeprom_pkg::TIMER_W-1:0] timer;
  logic [eeprom_pkg::TIMER_W-1:0] timer_last;
  logic addr_set, got_data, verify_ok, master_nack, prog_lock;
  logic scl_rise, scl_fall, start_det, stop_det;
  logic byte_done, byte_end, tx_state, cmd_match, verify_eq;
  logic push, push_ready, pop_valid, page_clear;
  logic prog_start, lock_start, prog_last;
  logic [4:0] wr_off;
  logic [eeprom_pkg::ADDR_W-1:0] addr_step;

  // step within a page, upper page bits fixed
  function automatic logic [12:0] next_off(input logic [12:0] a);
    next_off = {a[12:5], a[4:0] + 5'h1};
  endfunction : next_off

  // step to the next page, offset kept
  function automatic logic [12:0] next_page(input logic [12:0] a);
    next_page = {a[12:5] + 8'h1, a[4:0]};
  endfunction : next_page

  // two-flop synchroniser for all pins, then one delay for edges
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      meta <= eeprom_pkg::PINS_RESET;
      pins <= eeprom_pkg::PINS_RESET;
      pins_d <= eeprom_pkg::PINS_RESET;
    end else begin
      meta <= {scl, sda_in, write_protect,
               dev_sel_bit2, dev_sel_bit1, dev_sel_bit0};
      pins <= meta;
      pins_d <= pins;
    end
  end

  // bus events
  assign scl_rise = pins.scl && !pins_d.scl;
  assign scl_fall = !pins.scl && pins_d.scl;
  assign start_det = pins.scl && pins_d.scl && pins_d.sda && !pins.sda;
  assign stop_det = pins.scl && pins_d.scl && !pins_d.sda && pins.sda;
  assign byte_done = scl_fall && bit_cnt == eeprom_pkg::BIT_ACK;
  assign byte_end = scl_fall && bit_cnt == eeprom_pkg::BIT_END;
  assign tx_state = state == eeprom_pkg::S_RDATA ||
                    state == eeprom_pkg::S_LOCK_READ;

  // command decode and data checks
  assign cmd_match = shift_in[7:4] == eeprom_pkg::CMD_PREFIX &&
                     shift_in[3:1] == pins.sel &&
                     !prog_busy;
  assign verify_eq = shift_in == mem[{addr[12:5], verify_cnt[4:0]}];
  assign rd_byte = state == eeprom_pkg::S_LOCK_READ ?
                   {lock[addr[12:5]], 7'h0} : mem[addr];
  assign addr_step = next_off(addr);
  assign wr_off = got_data ? addr_step[4:0] : addr[4:0];
  assign push = state == eeprom_pkg::S_WDATA && byte_done;
  assign push_word = '{offset: wr_off, data: shift_in};
  assign page_clear = state == eeprom_pkg::S_ADDR_LO && byte_done;

  // programming starts
  assign prog_start = stop_det && state == eeprom_pkg::S_WDATA &&
                      got_data && !prog_busy &&
                      !pins.wp &&
                      lock[addr[12:5]];
  assign lock_start = stop_det && state == eeprom_pkg::S_LOCK_VERIFY &&
                      verify_ok &&
                      verify_cnt == eeprom_pkg::VERIFY_LAST &&
                      !pins.wp && !prog_busy;
  assign timer_last = prog_lock ? LOCK_LAST : PROG_LAST;
  assign prog_last = prog_busy && timer == timer_last;

  // byte engine, protocol states and address counter
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      state <= eeprom_pkg::S_IDLE;
      bit_cnt <= '0;
      shift_in <= '0;
      tx_byte <= '0;
      sda_oe <= 1'b0;
      addr <= '0;
      addr_set <= 1'b0;
      got_data <= 1'b0;
      lock_ctl <= '0;
      verify_cnt <= '0;
      verify_ok <= 1'b0;
      master_nack <= 1'b0;
    end else if (start_det) begin
      state <= eeprom_pkg::S_CMD;
      bit_cnt <= '0;
      sda_oe <= 1'b0;
      got_data <= 1'b0;
    end else if (stop_det) begin
      state <= eeprom_pkg::S_IDLE;
      sda_oe <= 1'b0;
      addr_set <= 1'b0;
      got_data <= 1'b0;
      if (lock_start) begin
        addr[4:0] <= '1;
      end
    end else if (state == eeprom_pkg::S_IDLE ||
                 state == eeprom_pkg::S_IGNORE) begin
      sda_oe <= 1'b0;
    end else if (scl_rise) begin
      if (bit_cnt < eeprom_pkg::BIT_ACK) begin
        shift_in <= {shift_in[6:0], pins.sda};
      end else begin
        master_nack <= pins.sda;
      end
      bit_cnt <= bit_cnt + 4'h1;
    end else if (byte_end) begin
      bit_cnt <= '0;
      sda_oe <= 1'b0;
      if (tx_state) begin
        if (master_nack) begin
          state <= eeprom_pkg::S_IGNORE;
        end else begin
          tx_byte <= rd_byte;
          sda_oe <= !rd_byte[7];
          if (state == eeprom_pkg::S_LOCK_READ) begin
            addr <= next_page(addr);
          end else begin
            addr <= addr + 13'h1;
          end
        end
      end
    end else if (scl_fall && tx_state) begin
      tx_byte <= {tx_byte[6:0], 1'b0};
      sda_oe <= bit_cnt == eeprom_pkg::BIT_ACK ? 1'b0 : !tx_byte[6];
    end else if (byte_done) begin
      sda_oe <= 1'b1;
      unique case (state)
        eeprom_pkg::S_CMD: begin
          if (!cmd_match) begin
            sda_oe <= 1'b0;
            state <= eeprom_pkg::S_IGNORE;
          end else if (shift_in[0]) begin
            state <= eeprom_pkg::S_RDATA;
          end else if (addr_set) begin
            state <= eeprom_pkg::S_LOCK_CTL;
            addr_set <= 1'b0;
          end else begin
            state <= eeprom_pkg::S_ADDR_HI;
          end
        end
        eeprom_pkg::S_ADDR_HI: begin
          addr[12:8] <= shift_in[4:0];
          state <= eeprom_pkg::S_ADDR_LO;
        end
        eeprom_pkg::S_ADDR_LO: begin
          addr[7:0] <= shift_in;
          addr_set <= 1'b1;
          got_data <= 1'b0;
          state <= eeprom_pkg::S_WDATA;
        end
        eeprom_pkg::S_WDATA: begin
          if (push_ready) begin
            addr[4:0] <= wr_off;
            got_data <= 1'b1;
          end else begin
            sda_oe <= 1'b0;
            state <= eeprom_pkg::S_IGNORE;
          end
        end
        eeprom_pkg::S_LOCK_CTL: begin
          lock_ctl <= shift_in[1:0];
          verify_cnt <= '0;
          verify_ok <= 1'b1;
          case (shift_in[1:0])
            eeprom_pkg::LOCK_READ_CODE: state <= eeprom_pkg::S_LOCK_READ;
            eeprom_pkg::LOCK_SET_CODE,
            eeprom_pkg::LOCK_CLEAR_CODE: state <= eeprom_pkg::S_LOCK_VERIFY;
            default: begin
              sda_oe <= 1'b0;
              state <= eeprom_pkg::S_IGNORE;
            end
          endcase
        end
        eeprom_pkg::S_LOCK_VERIFY: begin
          verify_cnt <= verify_cnt + 6'h1;
          if (!verify_eq ||
              verify_cnt == eeprom_pkg::VERIFY_LAST) begin
            verify_ok <= 1'b0;
            sda_oe <= 1'b0;
            state <= eeprom_pkg::S_IGNORE;
          end
        end
        default: sda_oe <= 1'b0;
      endcase
    end else if (scl_fall) begin
      sda_oe <= 1'b0;
    end
  end

  // open-drain line only ever pulled low
  always_ff @(posedge mclk) begin
    sda_out <= 1'b0;
  end

  // page buffer filled through the fifo
  page_fifo #(.WIDTH(PW), .DEPTH(FIFO_DEPTH)) u_fifo (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .in_valid(push),
    .in_data(push_word),
    .in_ready(push_ready),
    .out_valid(pop_valid),
    .out_data(pop_word),
    .out_ready(!prog_busy)
  );

  // drain into page buffer, marking touched offsets
  always_ff @(posedge mclk) begin
    if (sys_rst || page_clear) begin
      pmask <= '0;
    end else if (pop_valid && !prog_busy) begin
      pbuf[pop_word.offset] <= pop_word.data;
      pmask[pop_word.offset] <= 1'b1;
    end
  end

  // programming timer
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      prog_busy <= 1'b0;
      prog_lock <= 1'b0;
      timer <= '0;
    end else if (prog_start || lock_start) begin
      prog_busy <= 1'b1;
      prog_lock <= lock_start;
      timer <= '0;
    end else if (prog_last) begin
      prog_busy <= 1'b0;
    end else if (prog_busy) begin
      timer <= timer + 1'b1;
    end
  end

  // data array: erase touched bytes, then write them
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      for (int i = 0; i < eeprom_pkg::MEM_BYTES; i++) begin
        mem[i] <= eeprom_pkg::ERASED_BYTE;
      end
    end else if (prog_busy && !prog_lock) begin
      for (int i = 0; i < eeprom_pkg::PAGE_BYTES; i++) begin
        if (pmask[i] && timer == '0) begin
          mem[{addr[12:5], 5'(i)}] <= eeprom_pkg::ERASED_BYTE;
        end else if (pmask[i] && prog_last) begin
          mem[{addr[12:5], 5'(i)}] <= pbuf[i];
        end
      end
    end
  end

  // lock bits, one means unlocked
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      lock <= '1;
    end else if (prog_last && prog_lock) begin
      lock[addr[12:5]] <= lock_ctl == eeprom_pkg::LOCK_CLEAR_CODE;
    end
  end

  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  a_busy_nack: assert property (
    state == eeprom_pkg::S_CMD && byte_done && prog_busy
    |=> !sda_oe && state == eeprom_pkg::S_IGNORE)
    else $error("command acknowledged while busy");
  a_prefix_nack: assert property (
    state == eeprom_pkg::S_CMD && byte_done &&
    shift_in[7:4] != eeprom_pkg::CMD_PREFIX
    |=> !sda_oe [*2])
    else $error("bad prefix acknowledged");
  a_select_match: assert property (
    state == eeprom_pkg::S_CMD && byte_done && shift_in[3:1] != pins.sel
    |=> state == eeprom_pkg::S_IGNORE)
    else $error("foreign select accepted");
  a_wp_blocks: assert property (
    stop_det && pins.wp |=> !$rose(prog_busy))
    else $error("programming under write protect");
  a_lock_blocks: assert property (
    stop_det && state == eeprom_pkg::S_WDATA && !lock[addr[12:5]]
    |=> !$rose(prog_busy))
    else $error("locked page programmed");
  a_write_wrap: assert property (
    push && push_ready && got_data
    |=> addr[12:5] == $past(addr[12:5]) &&
        addr[4:0] == $past(addr[4:0]) + 5'h1)
    else $error("write address step wrong");
  a_read_step: assert property (
    byte_end && state == eeprom_pkg::S_RDATA && !master_nack
    |=> addr == $past(addr) + 13'h1)
    else $error("read address step wrong");
  a_prog_bound: assert property (
    prog_busy && !prog_lock |-> timer <= PROG_LAST)
    else $error("data programming too long");
  a_lock_bound: assert property (
    prog_busy && prog_lock |-> timer <= LOCK_LAST)
    else $error("lock programming too long");
  a_abort_write: assert property (
    start_det && !prog_busy |=> !prog_busy)
    else $error("restart began programming");
  a_addr_hold: assert property (
    prog_busy && $past(prog_busy) |-> $stable(addr))
    else $error("address moved while busy");

  c_data_prog: cover property (prog_start);
  c_lock_prog: cover property (lock_start);
  c_seq_read: cover property (
    byte_end && state == eeprom_pkg::S_RDATA && !master_nack);
  c_poll_nack: cover property (
    state == eeprom_pkg::S_CMD && byte_done && prog_busy);
endmodule : serial_eeprom_slave

/* dv/i2c_master_model.sv */
`timescale 1ns/1ps
module i2c_master_model (
  input wire logic mclk,
  input wire logic sda,
  output logic scl,
  output logic sda_low
);
  int lo_len = 8;
  // idle bus: clock parked high, data released to the pull-up
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // one sixteenth of the 125 ns bus period, free running against mclk
  task automatic tick(input int n);
    #(n * 7.8125);
  endtask : tick
  // one clock pulse, data sampled mid high phase
  task automatic bit_cycle(input logic b, output logic seen);
    tick(lo_len / 2);
    sda_low = !b;
    tick(lo_len - lo_len / 2);
    scl = 1'b1;
    tick(4);
    seen = sda;
    tick(4);
    scl = 1'b0;
  endtask : bit_cycle
  // start, also serves as repeated start
  task automatic start();
    @(negedge mclk);
    tick(4);
    sda_low = 1'b0;
    tick(4);
    scl = 1'b1;
    tick(8);
    sda_low = 1'b1;
    tick(8);
    scl = 1'b0;
  endtask : start
  task automatic stop();
    tick(4);
    sda_low = 1'b1;
    tick(4);
    scl = 1'b1;
    tick(8);
    sda_low = 1'b0;
    tick(8);
  endtask : stop
  // msb first, ninth pulse reads the acknowledge
  task automatic send(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_cycle(b[i], s);
    bit_cycle(1'b1, s);
    ack = !s;
  endtask : send
  task automatic recv(input logic ack, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_cycle(1'b1, s);
      b[i] = s;
    end
    bit_cycle(!ack, s);
  endtask : recv
endmodule : i2c_master_model

/* dv/serial_eeprom_slave_with_page_lock_bench.sv */
`timescale 1ns/1ps
module serial_eeprom_slave_with_page_lock_bench;
  localparam int prog_len = 300;
  localparam int lock_len = 100;
  logic mclk, sys_rst, scl, sda, sda_low, write_protect;
  logic sda_out, sda_oe, prog_busy, ack;
  logic [2:0] sel;
  logic [7:0] mem [8192];
  logic lock [256];
  logic [31:0] rng = 32'h000103bb;
  int cur, n_fail, comparisons, cycles, busy_run, busy_len;
  // open drain wire with pull-up
  assign sda = !(sda_oe | sda_low);
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  i2c_master_model i2c_master_model_i (.mclk(mclk), .sda(sda), .scl(scl),
    .sda_low(sda_low));
  serial_eeprom_slave #(.PROG_CYCLES(prog_len), .LOCK_CYCLES(lock_len),
    .FIFO_DEPTH(16)) serial_eeprom_slave_i (.mclk(mclk),
    .sys_rst(sys_rst), .scl(scl), .sda_in(sda),
    .write_protect(write_protect), .dev_sel_bit0(sel[0]),
    .dev_sel_bit1(sel[1]), .dev_sel_bit2(sel[2]), .sda_out(sda_out),
    .sda_oe(sda_oe), .prog_busy(prog_busy));
  function automatic logic [31:0] rand_word();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction : rand_word
  task automatic complete_run();
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : complete_run
  task automatic check(input string what, input logic [31:0] seen,
    input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // busy run length and hang guard
  always @(posedge mclk) begin
    cycles++;
    if (prog_busy === 1'b1) busy_run++;
    else if (busy_run != 0) begin
      busy_len = busy_run;
      busy_run = 0;
    end
    if (cycles > 90000) begin
      n_fail++;
      complete_run();
    end
  end
  task automatic cmd(input logic rd, input logic exp);
    i2c_master_model_i.start();
    i2c_master_model_i.send({eeprom_pkg::CMD_PREFIX, sel, rd}, ack);
    check("cmd ack", ack, exp);
  endtask : cmd
  task automatic addr_phase(input logic [12:0] a);
    cmd(1'b0, 1'b1);
    i2c_master_model_i.send({3'h0, a[12:8]}, ack);
    check("hi ack", ack, 1);
    i2c_master_model_i.send(a[7:0], ack);
    check("lo ack", ack, 1);
    cur = a;
  endtask : addr_phase
  task automatic busy_check(input logic go, input int len, input logic poll);
    int t;
    t = 0;
    busy_len = 0;
    if (!go) begin
      repeat (30) @(negedge mclk);
      check("idle busy", prog_busy, 0);
      return;
    end
    while (prog_busy !== 1'b1 && t < 10) begin
      @(negedge mclk);
      t++;
    end
    check("busy start", prog_busy, 1);
    if (poll) begin
      cmd(1'b1, 1'b0);
      i2c_master_model_i.stop();
    end
    t = 0;
    while (prog_busy !== 1'b0 && t < len + 10) begin
      @(negedge mclk);
      t++;
    end
    @(negedge mclk);
    check("busy length", busy_len, len);
  endtask : busy_check
  task automatic wr(input logic [12:0] a, input int n);
    logic [7:0] d;
    logic [12:0] w;
    logic go;
    logic [12:0] wa [$];
    logic [7:0] wd [$];
    addr_phase(a);
    w = a;
    for (int i = 0; i < n; i++) begin
      d = 8'(rand_word());
      i2c_master_model_i.send(d, ack);
      check("data ack", ack, 1);
      wa.push_back(w);
      wd.push_back(d);
      cur = w;
      w = {w[12:5], w[4:0] + 5'h01};
    end
    i2c_master_model_i.stop();
    go = !write_protect && lock[a[12:5]];
    foreach (wa[i]) if (go) mem[wa[i]] = wd[i];
    busy_check(go, prog_len, 1'b1);
  endtask : wr
  task automatic rd(input int a, input int n);
    logic [7:0] b;
    if (a >= 0) addr_phase(a[12:0]);
    cmd(1'b1, 1'b1);
    for (int i = 0; i < n; i++) begin
      i2c_master_model_i.recv(i < n - 1, b);
      check("read data", b, mem[cur]);
      cur = (cur + 1) % 8192;
    end
    i2c_master_model_i.stop();
  endtask : rd
  task automatic lock_op(input logic [7:0] p, input logic [7:0] ctl,
    input int n, input int bad);
    logic [7:0] b;
    addr_phase({p, 5'h00});
    cmd(1'b0, 1'b1);
    i2c_master_model_i.send(ctl, ack);
    check("ctl ack", ack, ctl[1:0] != 2'h2);
    for (int i = 0; i < n; i++) begin
      if (ctl[1:0] == eeprom_pkg::LOCK_READ_CODE) begin
        i2c_master_model_i.recv(i < n - 1, b);
        check("lock read", b, {lock[p], 7'h00});
        p++;
      end else begin
        b = mem[{p, i[4:0]}] ^ {7'h00, i == bad};
        i2c_master_model_i.send(b, ack);
        check("verify ack", ack, i != bad);
      end
    end
    i2c_master_model_i.stop();
    if (ctl[0] && bad > 31) begin
      lock[p] = ctl[1];
      cur = {p, 5'h1f};
    end
    busy_check(ctl[0] && bad > 31, lock_len, 1'b0);
  endtask : lock_op
  // main sequence
  initial begin
    sys_rst = 1'b1;
    write_protect = 1'b0;
    sel = 3'h5;
    foreach (mem[i]) mem[i] = 8'hff;
    foreach (lock[i]) lock[i] = 1'b1;
    repeat (6) @(negedge mclk);
    sys_rst = 1'b0;
    check("reset busy", prog_busy, 0);
    check("reset oe", sda_oe, 0);
    check("sda out", sda_out, 0);
    repeat (4) @(negedge mclk);
    // foreign select bits, then a foreign prefix
    for (int k = 0; k < 2; k++) begin
      i2c_master_model_i.start();
      b_send(k);
      check("foreign cmd", ack, 0);
      i2c_master_model_i.stop();
    end
    @(negedge mclk) sel = 3'h2;
    wr(13'h1ffe, 4);
    rd(-1, 3);
    rd(13'h1ffd, 5);
    i2c_master_model_i.lo_len = 20;
    wr(13'h0000, 16);
    i2c_master_model_i.lo_len = 8;
    rd(0, 17);
    @(negedge mclk) write_protect = 1'b1;
    wr(13'h0040, 2);
    @(negedge mclk) write_protect = 1'b0;
    rd(13'h0040, 2);
    lock_op(8'h00, 8'h01, 6, 5);
    lock_op(8'h00, 8'(rand_word() & 32'hfc) | 8'h01, 32, 99);
    lock_op(8'hff, 8'(rand_word() & 32'hfc), 2, 0);
    lock_op(8'h00, 8'h02, 0, 0);
    wr(13'h0003, 1);
    rd(13'h0003, 1);
    lock_op(8'h00, 8'(rand_word() & 32'hfc) | 8'h03, 32, 99);
    wr(13'h0003, 1);
    rd(13'h0003, 1);
    complete_run();
  end
  task automatic b_send(input int k);
    if (k == 0) i2c_master_model_i.send({eeprom_pkg::CMD_PREFIX, ~sel, 1'b0},
      ack);
    else i2c_master_model_i.send({4'h2, sel, 1'b1}, ack);
  endtask : b_send
endmodule : serial_eeprom_slave_with_page_lock_bench
